// ===== core/uor_out_ep.sv
// receive side of a single-bank usb out endpoint: bank store, handshake, firmware read port
// assumes the packet front end runs on mclk and starts a packet only after the last handshake
// What this block does
// - isochronous out never lands in single bank
// - busy bank answers non-iso out packet with nak
// - free bank stores payload and acks non-iso packets automatically
// - accepted payload sets the bank-full flag
// - interrupt pending while bank-full flag set
// - byte count field reports stored bytes
// - firmware reads payload through fifo data port
// - cleared flag makes bank accept next packet
`timescale 1ns/1ps
module uor_out_ep
    import uor_pkg::*;
#(
    parameter int MAX_PKT = UOR_MAX_PKT,
    parameter int FIFO_DEPTH = UOR_FIFO_DEPTH
) (
    input wire logic mclk,                                  // 40 MHz clock
    input wire logic rst,                                   // synchronous reset, active high
    input wire logic ce,                                    // clock enable, freezes all state
    input wire logic rx_start,                              // pulse: out data packet begins
    input wire logic rx_iso,                                // packet belongs to isochronous traffic
    input wire logic rx_valid,                              // payload byte offered
    input wire uor_pkg::uor_byte_s rx_in,                   // payload byte with end marker
    output logic rx_ready,                                  // byte taken when high with rx_valid
    output uor_pkg::uor_hs_s hs_out,                        // one-cycle handshake answer
    input wire logic ep_dual_bank,                          // endpoint configured for ping-pong
    input wire logic bank_clear,                            // firmware clears rx_bank0_full
    input wire logic fifo_rd,                               // firmware reads endpoint_fifo_data
    output logic rx_bank0_full,                             // bank holds an accepted payload
    output logic [uor_pkg::UOR_CNT_W-1:0] rx_byte_count,    // bytes held in the bank
    output logic [uor_pkg::UOR_DATA_W-1:0] endpoint_fifo_data, // byte returned by the last read
    output logic irq_pending,                               // endpoint interrupt request
    output logic iso_reject                                 // last packet was iso on a single bank
);
    import uor_pkg::*;

    typedef enum logic [1:0] {UOR_IDLE, UOR_STORE, UOR_DROP} uor_state_e;

    logic [UOR_DATA_W-1:0] bank [MAX_PKT];
    uor_state_e st_r, st_nxt;
    logic full_r, full_nxt;
    logic irq_r, irq_nxt;
    logic iso_r, iso_nxt;
    logic iso_rej_r, iso_rej_nxt;
    logic [UOR_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [UOR_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [UOR_DATA_W-1:0] dout_r, dout_nxt;
    uor_hs_s hs_r, hs_nxt;
    logic f_in_ready, f_out_valid, f_out_ready;
    uor_byte_s f_out;
    logic bank_wr;
    logic room;

    uor_fifo #(
        .WIDTH($bits(uor_byte_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .in_valid(rx_valid),
        .in_ready(f_in_ready),
        .in_data(rx_in),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out)
    );

    // the bank has one port; a firmware read wins and the drain stalls for that cycle
    assign f_out_ready = !fifo_rd && (st_r != UOR_IDLE);
    assign room = (cnt_r < UOR_CNT_W'(MAX_PKT));
    assign bank_wr = f_out_valid && f_out_ready && (st_r == UOR_STORE) && room;

    always_comb
    begin
        st_nxt = st_r;
        full_nxt = full_r;
        iso_nxt = iso_r;
        iso_rej_nxt = iso_rej_r;
        cnt_nxt = cnt_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        dout_nxt = dout_r;
        hs_nxt = UOR_HS_RST;
        case (st_r)
            UOR_IDLE:
            begin
                if (rx_start)
                begin
                    iso_nxt = rx_iso;
                    iso_rej_nxt = rx_iso && !ep_dual_bank;
                    wp_nxt = UOR_PTR_RST;
                    if (full_r || (rx_iso && !ep_dual_bank))
                    begin
                        st_nxt = UOR_DROP;
                    end
                    else
                    begin
                        st_nxt = UOR_STORE;
                        cnt_nxt = UOR_CNT_RST;
                    end
                end
            end
            UOR_STORE:
            begin
                if (f_out_valid && f_out_ready)
                begin
                    // bytes past the bank size are discarded, count saturates
                    if (room)
                    begin
                        wp_nxt = wp_r + 1'b1;
                        cnt_nxt = cnt_r + 1'b1;
                    end
                    if (f_out.last)
                    begin
                        st_nxt = UOR_IDLE;
                        full_nxt = 1'b1;
                        rp_nxt = UOR_PTR_RST;
                        hs_nxt.valid = !iso_r;
                        hs_nxt.ack = !iso_r;
                    end
                end
            end
            UOR_DROP:
            begin
                if (f_out_valid && f_out_ready && f_out.last)
                begin
                    st_nxt = UOR_IDLE;
                    // isochronous traffic never gets a handshake
                    hs_nxt.valid = !iso_r;
                    hs_nxt.nak = !iso_r;
                end
            end
            default:
            begin
                st_nxt = UOR_IDLE;
            end
        endcase
        if (fifo_rd)
        begin
            dout_nxt = bank[rp_r];
            rp_nxt = rp_r + 1'b1;
        end
        // set wins over a clear landing in the same cycle
        if (bank_clear && !(full_nxt && !full_r))
        begin
            full_nxt = 1'b0;
            rp_nxt = UOR_PTR_RST;
        end
        irq_nxt = full_nxt;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= UOR_IDLE;
            full_r <= 1'b0;
            irq_r <= 1'b0;
            iso_r <= 1'b0;
            iso_rej_r <= 1'b0;
            cnt_r <= UOR_CNT_RST;
            wp_r <= UOR_PTR_RST;
            rp_r <= UOR_PTR_RST;
            dout_r <= UOR_DATA_RST;
            hs_r <= UOR_HS_RST;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            full_r <= full_nxt;
            irq_r <= irq_nxt;
            iso_r <= iso_nxt;
            iso_rej_r <= iso_rej_nxt;
            cnt_r <= cnt_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            dout_r <= dout_nxt;
            hs_r <= hs_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (ce && bank_wr)
        begin
            bank[wp_r] <= f_out.data;
        end
    end

    assign rx_ready = f_in_ready;
    assign hs_out = hs_r;
    assign rx_bank0_full = full_r;
    assign rx_byte_count = cnt_r;
    assign endpoint_fifo_data = dout_r;
    assign irq_pending = irq_r;
    assign iso_reject = iso_rej_r;
endmodule

// ===== include/uor_pkg.sv
// shared constants and carriers for the single-bank usb out endpoint receiver
// assumes one clock domain (mclk) and a link front end built from same-clock logic
package uor_pkg;
    localparam int UOR_MAX_PKT = 64;        // bank capacity in bytes
    localparam int UOR_FIFO_DEPTH = 4;      // receive buffer words
    localparam int UOR_DATA_W = 8;
    localparam int UOR_CNT_W = 7;           // holds 0..UOR_MAX_PKT
    localparam int UOR_PTR_W = 6;           // addresses the bank
    localparam logic [UOR_CNT_W-1:0] UOR_CNT_RST = 7'h00;
    localparam logic [UOR_PTR_W-1:0] UOR_PTR_RST = 6'h00;
    localparam logic [UOR_DATA_W-1:0] UOR_DATA_RST = 8'h00;

    typedef struct packed {
        logic [UOR_DATA_W-1:0] data;
        logic last;
    } uor_byte_s;

    typedef struct packed {
        logic valid;
        logic ack;
        logic nak;
    } uor_hs_s;

    localparam uor_hs_s UOR_HS_RST = '{valid: 1'b0, ack: 1'b0, nak: 1'b0};
endpackage

// ===== core/uor_fifo.sv
// small synchronous fifo with valid/ready on both sides, registered flags
// assumes the filling side honours in_ready and the draining side honours out_valid
`timescale 1ns/1ps
module uor_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic mclk,                 // clock
    input wire logic rst,                  // synchronous reset, active high
    input wire logic ce,                   // clock enable
    input wire logic in_valid,             // producer offers a word
    output logic in_ready,                 // room for a word
    input wire logic [WIDTH-1:0] in_data,  // word written
    output logic out_valid,                // a word is held
    input wire logic out_ready,            // consumer takes the word
    output logic [WIDTH-1:0] out_data      // oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic in_ready_r, in_ready_nxt, out_valid_r, out_valid_nxt;
    logic push, pop;

    assign push = in_valid && in_ready_r;
    assign pop = out_ready && out_valid_r;
    assign in_ready = in_ready_r;
    assign out_valid = out_valid_r;
    assign out_data = mem[rp_r];

    always_comb
    begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push)
        begin
            wp_nxt = (wp_r == LAST_IDX) ? '0 : wp_r + 1'b1;
        end
        if (pop)
        begin
            rp_nxt = (rp_r == LAST_IDX) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
        // flags come from the next count so they stay honest yet registered
        in_ready_nxt = (cnt_nxt != FULL_CNT);
        out_valid_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b0;
            out_valid_r <= 1'b0;
        end
        else if (ce)
        begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_ready_r <= in_ready_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (ce && push)
        begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// ===== verif/uor_out_ep_chk.sv
// checker for uor_out_ep: handshake, flag, count and read port relations
// assumes one clock, mclk, with rst synchronous and active high
`timescale 1ns/1ps
module uor_out_ep_chk
    import uor_pkg::*;
#(
    parameter int MAX_PKT = UOR_MAX_PKT
) (
    input wire logic mclk, // clock
    input wire logic rst, // sync reset
    input wire logic ce, // clock enable
    input wire logic bank_clear, // flag clear pulse
    input wire logic fifo_rd, // read pulse
    input wire uor_pkg::uor_hs_s hs_out, // handshake
    input wire logic rx_bank0_full, // bank flag
    input wire logic [uor_pkg::UOR_CNT_W-1:0] rx_byte_count, // stored bytes
    input wire logic [uor_pkg::UOR_DATA_W-1:0] endpoint_fifo_data, // read data
    input wire logic irq_pending // interrupt
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_ack;
        hs_out.valid && hs_out.ack;
    endsequence
    a_irq_tracks_full: assert property (irq_pending == rx_bank0_full)
        else $error("irq differs from bank flag");
    a_ack_sets_full: assert property (s_ack |-> rx_bank0_full && !$past(rx_bank0_full))
        else $error("ack without fresh bank flag");
    a_nak_no_store: assert property (hs_out.valid && hs_out.nak |-> $stable(rx_byte_count))
        else $error("nak changed byte count");
    a_count_in_range: assert property (rx_bank0_full |-> rx_byte_count inside {[1:MAX_PKT]})
        else $error("byte count out of range");
    a_full_holds: assert property (rx_bank0_full && !bank_clear |=> rx_bank0_full)
        else $error("bank flag dropped without clear");
    a_clear_frees: assert property (bank_clear && ce |=> !rx_bank0_full || hs_out.ack)
        else $error("clear did not free bank");
    a_data_holds: assert property (!fifo_rd |=> $stable(endpoint_fifo_data))
        else $error("read data moved without read");
    a_hs_one_cycle: assert property (hs_out.valid && ce |=> !hs_out.valid)
        else $error("handshake longer than one cycle");
endmodule
bind uor_out_ep uor_out_ep_chk #(.MAX_PKT(MAX_PKT)) uor_out_ep_chk_inst (.mclk(mclk), .rst(rst), .ce(ce),
    .bank_clear(bank_clear), .fifo_rd(fifo_rd), .hs_out(hs_out), .rx_bank0_full(rx_bank0_full),
    .rx_byte_count(rx_byte_count), .endpoint_fifo_data(endpoint_fifo_data), .irq_pending(irq_pending));

// ===== verif/uor_host_model.sv
// host stand-in: sends one out packet, byte k = base + k, returns the handshake seen
// assumes rx_ready and hs_out are registered and read just after the edge
`timescale 1ns/1ps
module uor_host_model
    import uor_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rx_ready, // byte taken
    input wire uor_pkg::uor_hs_s hs_out, // handshake
    output logic rx_start, // packet start
    output logic rx_iso, // iso packet
    output logic rx_valid, // byte offered
    output uor_pkg::uor_byte_s rx_in // payload byte
);
    initial
    begin
        rx_start = 1'b0;
        rx_iso = 1'b0;
        rx_valid = 1'b0;
        rx_in = '0;
    end
    task automatic send(input int n, input logic [7:0] base, input logic iso, output uor_hs_s hs);
        int k = 0;
        hs = '0;
        @(posedge mclk);
        rx_start <= 1'b1;
        rx_iso <= iso;
        rx_valid <= 1'b1;
        rx_in <= '{data: base, last: n == 1};
        while (k < n)
        begin
            @(posedge mclk);
            rx_start <= 1'b0;
            if (rx_ready)
            begin
                k++;
                rx_valid <= k < n;
                // released lines flip so a stale byte never reads as fresh
                rx_in <= '{data: k < n ? base + 8'(k) : ~rx_in.data, last: k == n - 1};
            end
        end
        for (int w = 0; w < 40 && !hs.valid; w++)
        begin
            @(posedge mclk);
            hs = hs_out;
        end
    endtask
endmodule

// ===== verif/uor_out_ep_tb.sv
// bench for uor_out_ep: reset, packet table, then nak, iso and second reset cases
// assumes uor_host_model drives the link side and the checker is bound
`timescale 1ns/1ps
module uor_out_ep_tb;
    import uor_pkg::*;
    typedef struct {int n; logic [7:0] base; logic [6:0] cnt;} uor_row_s;
    localparam uor_hs_s hs_ack = '{valid: 1'b1, ack: 1'b1, nak: 1'b0};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ep_dual_bank = 1'b0;
    logic bank_clear = 1'b0;
    logic fifo_rd = 1'b0;
    logic rx_start, rx_iso, rx_valid, rx_ready, rx_bank0_full, irq_pending, iso_reject;
    uor_byte_s rx_in;
    uor_hs_s hs_out, hs;
    logic [UOR_CNT_W-1:0] rx_byte_count;
    logic [UOR_DATA_W-1:0] endpoint_fifo_data;
    int err_total = 0;
    int checked = 0;
    // last row overflows the bank: extra bytes dropped, count saturates
    uor_row_s rows [4] = '{'{1, 8'h10, 7'h01}, '{4, 8'ha0, 7'h04}, '{64, 8'h00, 7'h40}, '{66, 8'hc0, 7'h40}};
    always #12.5 mclk = ~mclk;
    uor_out_ep uor_out_ep_inst (.mclk(mclk), .rst(rst), .ce(ce), .rx_start(rx_start), .rx_iso(rx_iso),
        .rx_valid(rx_valid), .rx_in(rx_in), .rx_ready(rx_ready), .hs_out(hs_out), .ep_dual_bank(ep_dual_bank),
        .bank_clear(bank_clear), .fifo_rd(fifo_rd), .rx_bank0_full(rx_bank0_full), .rx_byte_count(rx_byte_count),
        .endpoint_fifo_data(endpoint_fifo_data), .irq_pending(irq_pending), .iso_reject(iso_reject));
    uor_host_model uor_host_model_inst (.mclk(mclk), .rx_ready(rx_ready), .hs_out(hs_out), .rx_start(rx_start),
        .rx_iso(rx_iso), .rx_valid(rx_valid), .rx_in(rx_in));
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checked++;
        if (act !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic chk_f(input logic act, input logic exp);
        chk({7'h00, act}, {7'h00, exp});
    endtask
    task automatic chk_hs(input uor_hs_s act, input uor_hs_s exp);
        chk({5'h00, act}, {5'h00, exp});
    endtask
    // back to back reads; data of a read shows one edge after it is taken
    task automatic rd(input int n, input logic [7:0] base);
        for (int k = 0; k < n + 2; k++)
        begin
            @(posedge mclk);
            fifo_rd <= k < n;
            if (k >= 2)
                chk(endpoint_fifo_data, base + 8'(k - 2));
        end
    endtask
    task automatic clr;
        @(posedge mclk);
        bank_clear <= 1'b1;
        @(posedge mclk);
        bank_clear <= 1'b0;
        @(posedge mclk);
        chk_f(rx_bank0_full, 1'b0);
        chk_f(irq_pending, 1'b0);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d, comparisons %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge mclk);
        chk_f(rx_bank0_full, 1'b0);
        chk({1'b0, rx_byte_count}, 8'h00);
        chk_hs(hs_out, '0);
        chk_f(rx_ready, 1'b0);
        chk_f(irq_pending, 1'b0);
        chk(endpoint_fifo_data, 8'h00);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            uor_host_model_inst.send(rows[i].n, rows[i].base, 1'b0, hs);
            chk_hs(hs, hs_ack);
            chk_f(rx_ready, 1'b1);
            chk_f(rx_bank0_full, 1'b1);
            chk_f(irq_pending, 1'b1);
            chk({1'b0, rx_byte_count}, {1'b0, rows[i].cnt});
            rd(rows[i].cnt, rows[i].base);
            clr();
        end
        uor_host_model_inst.send(3, 8'h31, 1'b0, hs);
        chk_hs(hs, hs_ack);
        uor_host_model_inst.send(2, 8'h77, 1'b0, hs);
        chk_hs(hs, '{valid: 1'b1, ack: 1'b0, nak: 1'b1});
        chk({1'b0, rx_byte_count}, 8'h03);
        // clear and read offered while frozen must be lost: flag, data and read pointer hold
        ce <= 1'b0;
        bank_clear <= 1'b1;
        fifo_rd <= 1'b1;
        @(posedge mclk);
        ce <= 1'b1;
        bank_clear <= 1'b0;
        fifo_rd <= 1'b0;
        @(posedge mclk);
        chk_f(rx_bank0_full, 1'b1);
        chk_f(irq_pending, 1'b1);
        chk(endpoint_fifo_data, 8'hff);
        rd(3, 8'h31);
        clr();
        uor_host_model_inst.send(2, 8'h55, 1'b0, hs);
        chk_hs(hs, hs_ack);
        rd(2, 8'h55);
        clr();
        ep_dual_bank <= 1'b1;
        uor_host_model_inst.send(2, 8'h68, 1'b1, hs);
        chk_hs(hs, '0);
        chk_f(iso_reject, 1'b0);
        chk_f(rx_bank0_full, 1'b1);
        chk({1'b0, rx_byte_count}, 8'h02);
        rd(2, 8'h68);
        clr();
        ep_dual_bank <= 1'b0;
        uor_host_model_inst.send(2, 8'h90, 1'b1, hs);
        chk_hs(hs, '0);
        chk_f(iso_reject, 1'b1);
        chk_f(rx_bank0_full, 1'b0);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        chk_f(iso_reject, 1'b0);
        chk_f(rx_ready, 1'b0);
        rst <= 1'b0;
        uor_host_model_inst.send(1, 8'he1, 1'b0, hs);
        chk_hs(hs, hs_ack);
        print_verdict();
    end
    // the whole run needs under 2000 cycles; ten times that means a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        print_verdict();
    end
endmodule
